// *** hw/rbu_relative_branch_unit.sv ***
// Operation
// - Opcode 25 takes 3 cycles and branches only when carry is set.
// - Opcode 23 branches when carry or zero is set, else falls through.
// - Opcode 91 branches exactly when negative XOR overflow is one.
// - Opcode 2C branches only when the interrupt mask is zero.
// - Opcode 2D branches only when the interrupt mask is one.
// - Opcode 2B branches when negative is set.
// - Opcode 2A branches when negative is clear.
// - Opcode 26 branches when zero is clear.
// - Loads and stores of A, X or H:X copy the value's top bit into negative.
// - Opcode 20 always branches and completes in 3 cycles.
// - Target is opcode address plus two plus the signed final byte.
// - The 8-bit offset is sign-extended to 16 bits before the add.
// - A false condition continues at the byte after the two-byte branch.
// - 92 needs zero|(neg^ovf)=0, 93 is its complement, 90 needs neg^ovf=0.
// - Opcode 22 needs carry|zero=0; opcode 24 needs carry=0.
// - Opcode 27 branches on zero set, one decode for signed and unsigned.
// - Carry-set shares 25 and carry-clear shares 24, decoded identically.
// - Opcode 29 branches on half-carry one, opcode 28 on half-carry zero.
// - Opcode 21 never branches but still takes the offset and three cycles.
//
// Chosen here: the address map and the strobed register port.

`timescale 1ns/10ps
`default_nettype none

module rbu_relative_branch_unit (
  input wire logic core_clk_i,                          // Bus clock, 40 MHz
  input wire logic rst_n_i,                             // Synchronous reset, active low
  input wire logic [rbu_pkg::REG_ADDR_W-1:0] reg_addr_i, // Register byte address
  input wire logic [rbu_pkg::REG_DATA_W-1:0] reg_wdata_i, // Register write data
  input wire logic reg_wr_i,                            // Write strobe
  input wire logic reg_rd_i,                            // Read strobe
  output logic [rbu_pkg::REG_DATA_W-1:0] reg_rdata_o,   // Read data, cycle after strobe
  output rbu_pkg::rbu_mem_req_s mem_req_o,              // Program memory read request
  input wire logic [7:0] mem_data_i,                    // Memory byte, cycle after request
  input wire logic irq_pin_i,                           // External interrupt pin level
  input wire rbu_pkg::rbu_ldst_s ldst_i,                // Load/store value report
  output rbu_pkg::rbu_flags_s flags_o,                  // Condition flags register
  output logic [rbu_pkg::PC_W-1:0] pc_o,                // Program counter
  output logic busy_o,                                  // Branch in progress
  output logic done_o,                                  // One-cycle end of branch
  output logic taken_o                                  // Last branch was taken
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  rbu_pkg::rbu_state_e state_ff;
  rbu_pkg::rbu_state_e nxt_state;
  rbu_pkg::rbu_flags_s flags_ff;
  rbu_pkg::rbu_mem_req_s mem_req_ff;
  logic [rbu_pkg::PC_W-1:0] pc_ff;
  logic [rbu_pkg::PC_W-1:0] nxt_pc;
  logic [7:0] opcode_ff;
  logic [rbu_pkg::REG_DATA_W-1:0] rdata_ff;
  logic done_ff;
  logic busy_ff;
  logic taken_ff;
  logic badop_ff;
  logic wr_flags;
  logic wr_pc;
  logic go;
  logic clr_badop;
  logic exec;
  logic [1:0] eval;
  logic known_op;
  logic take;

  ////////////////////////////////////////////////////////////////////////////
  // Functions

  // Decodes a branch opcode against the flags and the pin: {known, take}
  function automatic logic [1:0] branch_eval(
    input logic [7:0] opc,
    input rbu_pkg::rbu_flags_s f,
    input logic pin
  );
    logic known;
    logic tk;
    known = 1'b1;
    tk = 1'b0;
    case (opc)
      rbu_pkg::OP_BRANCH_ALWAYS:
        tk = 1'b1;
      rbu_pkg::OP_BRANCH_NEVER:
        tk = 1'b0;
      rbu_pkg::OP_BRANCH_HIGHER:
        tk = ~(f.carry | f.zero);
      rbu_pkg::OP_BRANCH_LOWER_SAME:
        tk = f.carry | f.zero;
      rbu_pkg::OP_BRANCH_HIGHER_SAME:
        tk = ~f.carry;
      rbu_pkg::OP_BRANCH_LOWER:
        tk = f.carry;
      rbu_pkg::OP_BRANCH_NOT_EQUAL:
        tk = ~f.zero;
      rbu_pkg::OP_BRANCH_EQUAL:
        tk = f.zero;
      rbu_pkg::OP_BRANCH_HALFCARRY_CLEAR:
        tk = ~f.half;
      rbu_pkg::OP_BRANCH_HALFCARRY_SET:
        tk = f.half;
      rbu_pkg::OP_BRANCH_PLUS:
        tk = ~f.neg;
      rbu_pkg::OP_BRANCH_MINUS:
        tk = f.neg;
      rbu_pkg::OP_BRANCH_MASK_CLEAR:
        tk = ~f.imask;
      rbu_pkg::OP_BRANCH_MASK_SET:
        tk = f.imask;
      rbu_pkg::OP_BRANCH_IRQ_PIN_LOW:
        tk = ~pin;
      rbu_pkg::OP_BRANCH_IRQ_PIN_HIGH:
        tk = pin;
      rbu_pkg::OP_BRANCH_GREATER_EQUAL_SIGNED:
        tk = ~(f.neg ^ f.ovf);
      rbu_pkg::OP_BRANCH_LESS_SIGNED:
        tk = f.neg ^ f.ovf;
      rbu_pkg::OP_BRANCH_GREATER_SIGNED:
        tk = ~(f.zero | (f.neg ^ f.ovf));
      rbu_pkg::OP_BRANCH_LESS_EQUAL_SIGNED:
        tk = f.zero | (f.neg ^ f.ovf);
      default:
        known = 1'b0;
    endcase
    return {known, tk};
  endfunction

  // Widens a two's complement byte to program counter width
  function automatic logic [rbu_pkg::PC_W-1:0] sign_extend(input logic [7:0] b);
    return {{(rbu_pkg::PC_W - 8){b[7]}}, b};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Register bus decode

  // Writes to PC and CTRL only act while idle, so a branch never sees them
  assign wr_flags = reg_wr_i && (reg_addr_i == rbu_pkg::OFS_FLAGS);
  assign wr_pc = reg_wr_i && (reg_addr_i == rbu_pkg::OFS_PC) && (state_ff == rbu_pkg::RBU_IDLE);
  assign go = reg_wr_i && (reg_addr_i == rbu_pkg::OFS_CTRL)
    && reg_wdata_i[rbu_pkg::CTRL_GO_BIT] && (state_ff == rbu_pkg::RBU_IDLE);
  assign clr_badop = reg_wr_i && (reg_addr_i == rbu_pkg::OFS_STATUS)
    && reg_wdata_i[rbu_pkg::STAT_BADOP_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer

  // Three busy cycles: opcode read, offset read, execute
  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      rbu_pkg::RBU_IDLE:
        if (go)
        begin
          nxt_state = rbu_pkg::RBU_FETCH_OPC;
        end
      rbu_pkg::RBU_FETCH_OPC:
        nxt_state = rbu_pkg::RBU_FETCH_OFS;
      rbu_pkg::RBU_FETCH_OFS:
        nxt_state = rbu_pkg::RBU_EXEC;
      rbu_pkg::RBU_EXEC:
        nxt_state = rbu_pkg::RBU_IDLE;
      default:
        nxt_state = rbu_pkg::RBU_IDLE;
    endcase
  end

  // State register; busy is registered from the next state so the pin has no decode glitch
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      state_ff <= rbu_pkg::RBU_IDLE;
      busy_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      busy_ff <= (nxt_state != rbu_pkg::RBU_IDLE);
    end
  end

  // the offset byte is always fetched, even for the never form
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      mem_req_ff <= '0;
    end
    else
    begin
      mem_req_ff.rd <= go || (state_ff == rbu_pkg::RBU_FETCH_OPC);
      if (state_ff == rbu_pkg::RBU_FETCH_OPC)
      begin
        mem_req_ff.addr <= pc_ff + rbu_pkg::OFFSET_STEP;
      end
      else
      begin
        mem_req_ff.addr <= pc_ff;
      end
    end
  end

  // Opcode byte arrives while the offset read is out
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      opcode_ff <= 8'h00;
    end
    else if (state_ff == rbu_pkg::RBU_FETCH_OFS)
    begin
      opcode_ff <= mem_data_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Condition evaluation and target

  // Flags and pin are sampled in the execute cycle
  assign exec = (state_ff == rbu_pkg::RBU_EXEC);
  assign eval = branch_eval(opcode_ff, flags_ff, irq_pin_i);
  assign known_op = eval[1];
  assign take = eval[0];

  // Next program counter; an unknown opcode leaves it unchanged
  always_comb
  begin
    nxt_pc = pc_ff;
    if (wr_pc)
    begin
      nxt_pc = reg_wdata_i[rbu_pkg::PC_W-1:0];
    end
    else if (exec && known_op)
    begin
      if (take)
      begin
        // opcode address plus two plus offset
        nxt_pc = pc_ff + rbu_pkg::PC_STEP + sign_extend(mem_data_i);
      end
      else
      begin
        // fall through past the two bytes
        nxt_pc = pc_ff + rbu_pkg::PC_STEP;
      end
    end
  end

  // program counter moves at the end of the third cycle
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      pc_ff <= rbu_pkg::PC_RESET;
    end
    else
    begin
      pc_ff <= nxt_pc;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Condition flags register

  // only software and load/store reports write here, never a branch
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      flags_ff <= rbu_pkg::FLAGS_RESET;
    end
    else
    begin
      if (wr_flags)
      begin
        flags_ff <= reg_wdata_i[7:0] | rbu_pkg::FLAGS_FIXED_ONES;
      end
      // top bit of the moved value, after any software write
      if (ldst_i.valid)
      begin
        flags_ff.neg <= ldst_i.wide ? ldst_i.value[rbu_pkg::WIDE_MSB]
                                    : ldst_i.value[rbu_pkg::NARROW_MSB];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status

  // Done pulse and last outcome
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      done_ff <= 1'b0;
      taken_ff <= 1'b0;
    end
    else
    begin
      done_ff <= exec;
      if (exec)
      begin
        taken_ff <= known_op && take;
      end
    end
  end

  // Sticky bad-opcode flag; a new event wins over a clear in the same cycle
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      badop_ff <= 1'b0;
    end
    else if (exec && !known_op)
    begin
      badop_ff <= 1'b1;
    end
    else if (clr_badop)
    begin
      badop_ff <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data

  // Data stands only in the cycle after the strobe; unmapped reads give zero
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      rdata_ff <= '0;
    end
    else
    begin
      rdata_ff <= '0;
      if (reg_rd_i)
      begin
        case (reg_addr_i)
          rbu_pkg::OFS_FLAGS:
            rdata_ff[7:0] <= flags_ff;
          rbu_pkg::OFS_PC:
            rdata_ff[rbu_pkg::PC_W-1:0] <= pc_ff;
          rbu_pkg::OFS_STATUS:
          begin
            rdata_ff[rbu_pkg::STAT_BUSY_BIT] <= (state_ff != rbu_pkg::RBU_IDLE);
            rdata_ff[rbu_pkg::STAT_TAKEN_BIT] <= taken_ff;
            rdata_ff[rbu_pkg::STAT_BADOP_BIT] <= badop_ff;
            rdata_ff[rbu_pkg::STAT_OPC_LSB +: 8] <= opcode_ff;
          end
          default:
            rdata_ff <= '0;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  // All outputs come straight from flip-flops
  assign reg_rdata_o = rdata_ff;
  assign mem_req_o = mem_req_ff;
  assign flags_o = flags_ff;
  assign pc_o = pc_ff;
  assign busy_o = busy_ff;
  assign done_o = done_ff;
  assign taken_o = taken_ff;

endmodule

`default_nettype wire

// *** hw/rbu_pkg.sv ***
package rbu_pkg;

  // Program counter and bus widths
  localparam int unsigned PC_W = 16;
  localparam int unsigned REG_ADDR_W = 4;
  localparam int unsigned REG_DATA_W = 32;

  // Register byte offsets
  localparam logic [3:0] OFS_FLAGS = 4'h0;
  localparam logic [3:0] OFS_PC = 4'h4;
  localparam logic [3:0] OFS_CTRL = 4'h8;
  localparam logic [3:0] OFS_STATUS = 4'hc;

  // Field positions
  localparam int unsigned CTRL_GO_BIT = 0;
  localparam int unsigned STAT_BUSY_BIT = 0;
  localparam int unsigned STAT_TAKEN_BIT = 1;
  localparam int unsigned STAT_BADOP_BIT = 2;
  localparam int unsigned STAT_OPC_LSB = 8;
  localparam int unsigned NARROW_MSB = 7;
  localparam int unsigned WIDE_MSB = 15;

  // Reset values and fixed bits of the condition flags register
  localparam logic [7:0] FLAGS_RESET = 8'h68;
  localparam logic [7:0] FLAGS_FIXED_ONES = 8'h60;
  localparam logic [15:0] PC_RESET = 16'h0000;

  // Address steps: offset byte follows opcode, next instruction two bytes on
  localparam logic [15:0] OFFSET_STEP = 16'h0001;
  localparam logic [15:0] PC_STEP = 16'h0002;

  // Relative branch opcodes
  localparam logic [7:0] OP_BRANCH_ALWAYS = 8'h20;
  localparam logic [7:0] OP_BRANCH_NEVER = 8'h21;
  localparam logic [7:0] OP_BRANCH_HIGHER = 8'h22;
  localparam logic [7:0] OP_BRANCH_LOWER_SAME = 8'h23;
  localparam logic [7:0] OP_BRANCH_HIGHER_SAME = 8'h24;
  localparam logic [7:0] OP_BRANCH_CARRY_CLEAR = 8'h24;
  localparam logic [7:0] OP_BRANCH_LOWER = 8'h25;
  localparam logic [7:0] OP_BRANCH_CARRY_SET = 8'h25;
  localparam logic [7:0] OP_BRANCH_NOT_EQUAL = 8'h26;
  localparam logic [7:0] OP_BRANCH_EQUAL = 8'h27;
  localparam logic [7:0] OP_BRANCH_HALFCARRY_CLEAR = 8'h28;
  localparam logic [7:0] OP_BRANCH_HALFCARRY_SET = 8'h29;
  localparam logic [7:0] OP_BRANCH_PLUS = 8'h2a;
  localparam logic [7:0] OP_BRANCH_MINUS = 8'h2b;
  localparam logic [7:0] OP_BRANCH_MASK_CLEAR = 8'h2c;
  localparam logic [7:0] OP_BRANCH_MASK_SET = 8'h2d;
  localparam logic [7:0] OP_BRANCH_IRQ_PIN_LOW = 8'h2e;
  localparam logic [7:0] OP_BRANCH_IRQ_PIN_HIGH = 8'h2f;
  localparam logic [7:0] OP_BRANCH_GREATER_EQUAL_SIGNED = 8'h90;
  localparam logic [7:0] OP_BRANCH_LESS_SIGNED = 8'h91;
  localparam logic [7:0] OP_BRANCH_GREATER_SIGNED = 8'h92;
  localparam logic [7:0] OP_BRANCH_LESS_EQUAL_SIGNED = 8'h93;

  // Sequencer states
  typedef enum logic [1:0] {
    RBU_IDLE,
    RBU_FETCH_OPC,
    RBU_FETCH_OFS,
    RBU_EXEC
  } rbu_state_e;

  // Condition flags register layout, bit 7 down to bit 0
  typedef struct packed {
    logic ovf;
    logic one_b6;
    logic one_b5;
    logic half;
    logic imask;
    logic neg;
    logic zero;
    logic carry;
  } rbu_flags_s;

  // Program memory read request
  typedef struct packed {
    logic rd;
    logic [15:0] addr;
  } rbu_mem_req_s;

  // Load or store of A, X or H:X seen by the flag logic
  typedef struct packed {
    logic valid;
    logic wide;
    logic [15:0] value;
  } rbu_ldst_s;

endpackage

// *** bench/rbu_prog_mem.sv ***
`timescale 1ns/10ps
`default_nettype none

module rbu_prog_mem (
  input wire logic clk_i, // Bus clock
  input wire rbu_pkg::rbu_mem_req_s req_i, // Read request
  output var logic [7:0] data_o // Byte, cycle after request
);
  logic [7:0] mem [65536];

  // Answer one cycle on; otherwise flip the byte so a late sample shows
  always_ff @(posedge clk_i)
  begin
    if (req_i.rd)
      data_o <= mem[req_i.addr];
    else
      data_o <= ~data_o;
  end
endmodule

`default_nettype wire

// *** bench/rbu_relative_branch_unit_monitor.sv ***
`timescale 1ns/10ps
`default_nettype none

module rbu_relative_branch_unit_monitor (
  input wire logic core_clk_i, // Clock
  input wire logic rst_n_i, // Reset
  input wire logic [3:0] reg_addr_i, // Address
  input wire logic [31:0] reg_wdata_i, // Write data
  input wire logic reg_wr_i, // Write strobe
  input wire logic reg_rd_i, // Read strobe
  input wire logic [31:0] reg_rdata_o, // Read data
  input wire rbu_pkg::rbu_mem_req_s mem_req_o, // Fetch
  input wire logic [7:0] mem_data_i, // Fetched byte
  input wire logic irq_pin_i, // Pin level
  input wire rbu_pkg::rbu_ldst_s ldst_i, // Load/store
  input wire rbu_pkg::rbu_flags_s flags_o, // Flags
  input wire logic [15:0] pc_o, // Program counter
  input wire logic busy_o, // Busy
  input wire logic done_o, // Done
  input wire logic taken_o // Taken
);
  logic sh_ff;
  logic [15:0] opc_pc_ff;
  logic [7:0] opc_ff;
  logic [7:0] ofs_ff;
  logic known;
  logic [15:0] seq_pc;

  ////////////////////////////////////////////////////////////////////
  // Capture the fetch; the opcode lands while the second read is out
  always_ff @(posedge core_clk_i)
  begin
    sh_ff <= mem_req_o.rd;
    if (mem_req_o.rd && !sh_ff) opc_pc_ff <= mem_req_o.addr;
    if (mem_req_o.rd && sh_ff) opc_ff <= mem_data_i;
    if (!mem_req_o.rd && sh_ff) ofs_ff <= mem_data_i;
  end

  // Unknown opcodes leave the counter alone, so exclude them
  assign known = opc_ff[7:4] == 4'h2 || opc_ff[7:2] == 6'h24;
  assign seq_pc = opc_pc_ff + 16'h0002;

  ////////////////////////////////////////////////////////////////////
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);

  a_busy_span: assert property (
    $rose(busy_o) |-> busy_o[*3] ##1 (!busy_o && done_o)) else $error("busy span wrong");
  a_fetch_pair: assert property (
    $rose(busy_o) |-> mem_req_o.rd && mem_req_o.addr == pc_o ##1 mem_req_o.rd &&
    mem_req_o.addr == $past(mem_req_o.addr) + 16'h0001 ##1 !mem_req_o.rd)
    else $error("fetch order wrong");
  a_fall_through: assert property (
    done_o && known && !taken_o |-> pc_o == seq_pc) else $error("fall through wrong");
  a_taken_target: assert property (
    done_o && taken_o |-> pc_o == seq_pc + {{8{ofs_ff[7]}}, ofs_ff})
    else $error("target wrong");
  a_flags_kept: assert property (
    busy_o && !reg_wr_i && !ldst_i.valid |=> $stable(flags_o)) else $error("flags moved");
  a_neg_narrow: assert property (
    ldst_i.valid && !ldst_i.wide |=> flags_o.neg == $past(ldst_i.value[7]))
    else $error("narrow neg wrong");
  a_neg_wide: assert property (
    ldst_i.valid && ldst_i.wide |=> flags_o.neg == $past(ldst_i.value[15]))
    else $error("wide neg wrong");
  a_always_taken: assert property (
    done_o && opc_ff == 8'h20 |-> taken_o) else $error("always not taken");
  a_never_taken: assert property (
    done_o && opc_ff == 8'h21 |-> !taken_o) else $error("never was taken");
  a_mask_split: assert property (
    done_o && opc_ff[7:1] == 7'h16 |-> taken_o == (opc_ff[0] == flags_o.imask))
    else $error("mask branch wrong");
  a_pin_split: assert property (
    done_o && opc_ff[7:1] == 7'h17 |-> taken_o == (opc_ff[0] == $past(irq_pin_i)))
    else $error("pin branch wrong");
endmodule

bind rbu_relative_branch_unit rbu_relative_branch_unit_monitor u_mon (
  .core_clk_i, .rst_n_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
  .reg_rdata_o, .mem_req_o, .mem_data_i, .irq_pin_i, .ldst_i, .flags_o,
  .pc_o, .busy_o, .done_o, .taken_o);

`default_nettype wire

// *** bench/relative_branch_unit_bench.sv ***
`timescale 1ns/10ps
`default_nettype none

module relative_branch_unit_bench;
  logic core_clk_i, rst_n_i, reg_wr_i, reg_rd_i, irq_pin_i;
  logic [3:0] reg_addr_i;
  logic [31:0] reg_wdata_i, reg_rdata_o;
  rbu_pkg::rbu_mem_req_s mem_req_o;
  logic [7:0] mem_data_i;
  rbu_pkg::rbu_ldst_s ldst_i;
  rbu_pkg::rbu_flags_s flags_o;
  logic [15:0] pc_o;
  logic busy_o, done_o, taken_o;
  int failures, checked;

  rbu_relative_branch_unit dut (.core_clk_i, .rst_n_i, .reg_addr_i, .reg_wdata_i,
    .reg_wr_i, .reg_rd_i, .reg_rdata_o, .mem_req_o, .mem_data_i, .irq_pin_i,
    .ldst_i, .flags_o, .pc_o, .busy_o, .done_o, .taken_o);
  rbu_prog_mem mem_u (.clk_i(core_clk_i), .req_i(mem_req_o), .data_o(mem_data_i));

  // Free-running 40 MHz clock
  initial
  begin
    core_clk_i = 1'b0;
    forever #12.5 core_clk_i = ~core_clk_i;
  end

  ////////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e)
    begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask

  // Register bus: strobes move just after a rising edge
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge core_clk_i);
    reg_wr_i <= 1'b0;
  endtask

  task automatic rd(input string nm, input logic [3:0] a, input logic [31:0] e);
    @(posedge core_clk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge core_clk_i);
    reg_rd_i <= 1'b0;
    @(negedge core_clk_i);
    chk(nm, reg_rdata_o, e);
  endtask

  // Reference outcome, flags laid out V - - H I N Z C
  function automatic logic cond(input logic [7:0] o, input logic [7:0] f, input logic p);
    logic x;
    x = f[2] ^ f[7];
    case (o)
      8'h20: return 1'b1;
      8'h22: return !(f[0] | f[1]);
      8'h23: return f[0] | f[1];
      8'h24: return !f[0];
      8'h25: return f[0];
      8'h26: return !f[1];
      8'h27: return f[1];
      8'h28: return !f[4];
      8'h29: return f[4];
      8'h2a: return !f[2];
      8'h2b: return f[2];
      8'h2c: return !f[3];
      8'h2d: return f[3];
      8'h2e: return !p;
      8'h2f: return p;
      8'h90: return !x;
      8'h91: return x;
      8'h92: return !(f[1] | x);
      8'h93: return f[1] | x;
      default: return 1'b0;
    endcase
  endfunction

  // One branch from a given address; a hang ends the run at once
  task automatic run(input logic [15:0] pc, input logic [7:0] op, input logic [7:0] ofs,
                     input logic [7:0] fl, input logic pin, input logic tk, input logic bad);
    int n;
    logic [15:0] ep;
    mem_u.mem[pc] = op;
    mem_u.mem[pc + 16'h0001] = ofs;
    ep = bad ? pc : (tk ? pc + 16'h0002 + {{8{ofs[7]}}, ofs} : pc + 16'h0002);
    @(posedge core_clk_i);
    irq_pin_i <= pin;
    wr(4'h0, {24'h0, fl});
    wr(4'h4, {16'h0, pc});
    wr(4'h8, 32'h1);
    n = 0;
    while (done_o !== 1'b1 && n < 8)
    begin
      @(negedge core_clk_i);
      n++;
    end
    if (n == 8)
    begin
      failures++;
      summarize();
    end
    chk("cycles", n, 4);
    chk("pc", pc_o, ep);
    chk("taken", taken_o, tk);
    chk("flags", flags_o, fl | 8'h60);
    rd("status", 4'hc, {16'h0, op, 5'h0, bad, tk, 1'b0});
  endtask

  ////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    @(negedge core_clk_i);
    chk("flags_o", flags_o, 8'h68);
    chk("pc_o", pc_o, 16'h0000);
    chk("busy", {busy_o, done_o, taken_o}, 3'h0);
    rd("flags", 4'h0, 32'h68);
    rd("pc", 4'h4, 32'h0);
    rd("ctrl", 4'h8, 32'h0);
    rd("status", 4'hc, 32'h0);
    rd("unmapped", 4'h2, 32'h0);
  endtask

  // Both widths, with the other candidate top bit set to catch a swap
  task automatic t_ldst();
    logic w [4] = '{1'b1, 1'b1, 1'b0, 1'b0};
    logic [15:0] v [4] = '{16'h8000, 16'h0080, 16'h0080, 16'h8000};
    for (int i = 0; i < 4; i++)
    begin
      @(posedge core_clk_i);
      ldst_i <= '{1'b1, w[i], v[i]};
      @(posedge core_clk_i);
      ldst_i.valid <= 1'b0;
      @(negedge core_clk_i);
      chk("neg", flags_o.neg, i % 2 == 0);
    end
  endtask

  // Every opcode against flag sets; addresses near the top force wrap
  task automatic t_branches();
    logic [7:0] ops [20] = '{8'h20, 8'h21, 8'h22, 8'h23, 8'h24, 8'h25, 8'h26,
      8'h27, 8'h28, 8'h29, 8'h2a, 8'h2b, 8'h2c, 8'h2d, 8'h2e, 8'h2f, 8'h90,
      8'h91, 8'h92, 8'h93};
    logic [7:0] fls [8] = '{8'h02, 8'h61, 8'h62, 8'h64, 8'h68, 8'h70, 8'he0, 8'he4};
    for (int j = 0; j < 20; j++)
      for (int k = 0; k < 8; k++)
        run(16'(16'hff80 + j * 4 + k), ops[j], 8'(j * 37 + k * 50), fls[k], 1'(k),
            cond(ops[j], fls[k], 1'(k)), 1'b0);
  endtask

  // Undefined opcode: counter held, sticky status cleared by writing one
  task automatic t_bad();
    run(16'h0100, 8'h80, 8'h10, 8'h60, 1'b0, 1'b0, 1'b1);
    wr(4'hc, 32'h4);
    rd("status", 4'hc, {16'h0, 8'h80, 8'h00});
  endtask

  // Writes while busy: a PC write is refused, busy shows on the pin and in status
  task automatic t_busy();
    mem_u.mem[16'h0200] = 8'h20;
    mem_u.mem[16'h0201] = 8'h7e;
    mem_u.mem[16'h0280] = 8'h21;
    mem_u.mem[16'h0281] = 8'h00;
    wr(4'h4, 32'h0200);
    wr(4'h8, 32'h1);
    wr(4'h4, 32'h1234);
    @(negedge core_clk_i);
    chk("busy", busy_o, 1'b1);
    @(negedge core_clk_i);
    chk("done", done_o, 1'b1);
    chk("pc", pc_o, 16'h0280);
    wr(4'h8, 32'h1);
    rd("status", 4'hc, 32'h2003);
    @(negedge core_clk_i);
    chk("pc", pc_o, 16'h0282);
    chk("taken", taken_o, 1'b0);
  endtask

  initial
  begin
    rst_n_i = 1'b0;
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    reg_addr_i = 4'h0;
    reg_wdata_i = 32'h0;
    irq_pin_i = 1'b0;
    ldst_i = '0;
    failures = 0;
    checked = 0;
    repeat (2) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    t_reset();
    t_ldst();
    t_branches();
    t_bad();
    t_busy();
    summarize();
  end
endmodule

`default_nettype wire
